/* File: verilog/drb_block_ram.sv */
// dual clock block ram: 4 kbit array with a write port and a read port
// assumes both port clocks are synchronous lines sampled on i_clk, and the
// fabric holds i_cfg_active high while the preload image is loaded
//
// Overview of operation
// - The array holds 4096 bits whatever the shape chosen.
// - Shapes are 256x16, 512x8, 1024x4 and 2048x2 with 8 to 11 address bits.
// - In the 16-bit shape a mask bit of 0 writes its data bit, 1 keeps it.
// - The write port acts on its clock's rising edge unless falling is set.
// - The read port has its own clock and its own edge selection.
// - Write data, write address and read address are registered first.
// - The contents can be preloaded while the device is being configured.
// - Location zero cannot be preloaded and holds an unspecified value.
// - Fifo or dual-port use needs pointer and flag logic in the fabric.
`include "drb_regs.svh"

module drb_block_ram
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire drb_pkg::drb_shape_e i_shape,
  input wire logic i_wr_clk_fall,
  input wire logic i_rd_clk_fall,
  input wire drb_pkg::drb_wr_port_s i_wr,
  input wire drb_pkg::drb_rd_port_s i_rd,
  input wire logic i_cfg_active,
  input wire logic i_cfg_load,
  input wire logic [`DRB_WORD_W-1:0] i_cfg_addr,
  input wire logic [`DRB_DATA_W-1:0] i_cfg_data,
  output logic [`DRB_DATA_W-1:0] o_rd_data
);
  import drb_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // storage and port edges

  // one 16-bit wide physical array, 256 deep: 4 kbit in every shape
  logic [`DRB_DATA_W-1:0] mem [`DRB_WORDS];
  logic wr_edge;
  logic rd_edge;
  logic wr_ev;
  logic rd_ev;
  logic wr_go;
  logic rd_go;
  drb_wr_port_s wr_q;
  drb_rd_port_s rd_q;
  drb_loc_s wr_loc;
  drb_loc_s rd_loc;
  logic [`DRB_DATA_W-1:0] wr_bits;
  logic [`DRB_DATA_W-1:0] wr_aligned;
  logic [`DRB_DATA_W-1:0] wr_old;
  logic [`DRB_DATA_W-1:0] rd_val;
  logic cfg_take;

  drb_edge_det u_wr_edge
  (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_line(i_wr.wr_clk),
    .i_fall(i_wr_clk_fall),
    .o_pulse(wr_edge)
  );

  drb_edge_det u_rd_edge
  (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_line(i_rd.rd_clk),
    .i_fall(i_rd_clk_fall),
    .o_pulse(rd_edge)
  );

  // user ports are shut while the preload runs
  assign wr_ev = wr_edge & i_wr.wr_enable & i_wr.wr_clk_gate
    & ~i_cfg_active;
  assign rd_ev = rd_edge & i_rd.rd_enable & i_rd.rd_clk_gate
    & ~i_cfg_active;
  // address zero is never touched by the preload
  assign cfg_take = i_cfg_active & i_cfg_load
    & (i_cfg_addr != `DRB_LOCK_ADDR);

  ////////////////////////////////////////////////////////////////////////
  // input registers at the array

  // write address, data and mask captured on the port edge
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      wr_go <= 1'b0;
      wr_q <= '0;
    end
    else
    begin
      wr_go <= wr_ev;
      if (wr_ev)
        wr_q <= i_wr;
    end
  end

  // read address captured on its own edge
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      rd_go <= 1'b0;
      rd_q <= '0;
    end
    else
    begin
      rd_go <= rd_ev;
      if (rd_ev)
        rd_q <= i_rd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // shape mapping

  // a narrow lane sits inside one physical word
  always_comb
  begin
    wr_loc = drb_map(i_shape, wr_q.wr_addr);
    rd_loc = drb_map(i_shape, rd_q.rd_addr);
    wr_aligned = (wr_q.wr_data & wr_loc.lane) << wr_loc.off;
    if (i_shape == DRB_RAM_SHAPE_256_BY_16)
      wr_bits = ~wr_q.wr_mask;
    else
      wr_bits = wr_loc.lane << wr_loc.off;
    wr_old = mem[wr_loc.word];
    rd_val = (mem[rd_loc.word] >> rd_loc.off) & rd_loc.lane;
  end

  ////////////////////////////////////////////////////////////////////////
  // array update

  // preload wins over a user write still registered when configuration starts; user ports are shut after that
  always_ff @(posedge i_clk)
  begin
    if (cfg_take)
      mem[i_cfg_addr] <= i_cfg_data;
    else if (wr_go)
      mem[wr_loc.word] <= (wr_old & ~wr_bits)
        | (wr_aligned & wr_bits);
  end

  // read data hold between enabled reads; no bypass of a same-cycle write
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_rd_data <= `DRB_RD_DATA_RST;
    else if (rd_go)
      o_rd_data <= rd_val;
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  chk_wr_capture: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_ev |=> wr_go && wr_q == $past(i_wr))
    else $error("write port not captured on its edge");

  chk_wr_gate: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_edge && !(i_wr.wr_enable && i_wr.wr_clk_gate) |=> !wr_go)
    else $error("write taken without enable and clock gate");

  chk_wr_edge_pol: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_edge |-> i_wr.wr_clk != $past(i_wr.wr_clk)
      && i_wr.wr_clk == !i_wr_clk_fall)
    else $error("write edge of wrong polarity");

  chk_rd_edge_pol: assert property (@(posedge i_clk) disable iff (i_rst)
    rd_edge |-> i_rd.rd_clk != $past(i_rd.rd_clk)
      && i_rd.rd_clk == !i_rd_clk_fall)
    else $error("read edge of wrong polarity");

  chk_wr_bits_set: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_go && !cfg_take |=> (mem[$past(wr_loc.word)] & $past(wr_bits))
      == ($past(wr_aligned) & $past(wr_bits)))
    else $error("written bits do not match data");

  chk_mask_keep: assert property (@(posedge i_clk) disable iff (i_rst)
    wr_go && !cfg_take |=> (mem[$past(wr_loc.word)] & ~$past(wr_bits))
      == ($past(wr_old) & ~$past(wr_bits)))
    else $error("masked bits were changed");

  chk_rd_update: assert property (@(posedge i_clk) disable iff (i_rst)
    rd_ev |=> rd_go ##1 o_rd_data == $past(rd_val))
    else $error("read data not delivered two cycles after edge");

  chk_rd_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    !rd_go |=> $stable(o_rd_data))
    else $error("read data changed without a read");

  chk_zero_locked: assert property (@(posedge i_clk) disable iff (i_rst)
    i_cfg_load && i_cfg_addr == `DRB_LOCK_ADDR && !wr_go
      |=> mem[0] == $past(mem[0]))
    else $error("location zero was preloaded");

  cov_masked_write: cover property (@(posedge i_clk) disable iff (i_rst)
    wr_go && i_shape == DRB_RAM_SHAPE_256_BY_16 && wr_q.wr_mask != '0);
  cov_narrow_read: cover property (@(posedge i_clk) disable iff (i_rst)
    rd_go && i_shape == DRB_RAM_SHAPE_2048_BY_2);
  cov_preload_then_read: cover property (@(posedge i_clk)
    disable iff (i_rst) cfg_take ##[1:20] rd_ev);
endmodule // drb_block_ram

/* File: verilog/drb_regs.svh */
// constants of the dual clock block ram: sizes, shape codes, reset values
// assumes inclusion by the package and the design files by bare name
`ifndef DRB_REGS_SVH
`define DRB_REGS_SVH

`define DRB_TOTAL_BITS 4096
`define DRB_ADDR_W 11
`define DRB_DATA_W 16
`define DRB_WORDS 256
`define DRB_WORD_W 8
`define DRB_SHAPE_W 2
`define DRB_SHAPE_256_BY_16 2'h0
`define DRB_SHAPE_512_BY_8 2'h1
`define DRB_SHAPE_1024_BY_4 2'h2
`define DRB_SHAPE_2048_BY_2 2'h3
`define DRB_LANE_16 16'hFFFF
`define DRB_LANE_8 16'h00FF
`define DRB_LANE_4 16'h000F
`define DRB_LANE_2 16'h0003
`define DRB_RD_DATA_RST 16'h0000
`define DRB_LOCK_ADDR 8'h00

`endif

/* File: verilog/drb_pkg.sv */
// types of the dual clock block ram: shapes, port bundles, address map
// assumes drb_regs.svh is on the include path
`include "drb_regs.svh"

package drb_pkg;

  typedef enum logic [`DRB_SHAPE_W-1:0] {
    DRB_RAM_SHAPE_256_BY_16 = `DRB_SHAPE_256_BY_16,
    DRB_RAM_SHAPE_512_BY_8 = `DRB_SHAPE_512_BY_8,
    DRB_RAM_SHAPE_1024_BY_4 = `DRB_SHAPE_1024_BY_4,
    DRB_RAM_SHAPE_2048_BY_2 = `DRB_SHAPE_2048_BY_2
  } drb_shape_e;

  typedef struct packed {
    logic wr_clk;
    logic wr_enable;
    logic wr_clk_gate;
    logic [`DRB_ADDR_W-1:0] wr_addr;
    logic [`DRB_DATA_W-1:0] wr_data;
    logic [`DRB_DATA_W-1:0] wr_mask;
  } drb_wr_port_s;

  typedef struct packed {
    logic rd_clk;
    logic rd_enable;
    logic rd_clk_gate;
    logic [`DRB_ADDR_W-1:0] rd_addr;
  } drb_rd_port_s;

  typedef struct packed {
    logic [`DRB_WORD_W-1:0] word;
    logic [`DRB_DATA_W-1:0] lane;
    logic [3:0] off;
  } drb_loc_s;

  // narrow shapes pick a lane of a 16-bit physical word
  function automatic drb_loc_s drb_map(drb_shape_e shape,
                                       logic [`DRB_ADDR_W-1:0] a);
    drb_loc_s loc;
    loc = '0;
    case (shape)
      DRB_RAM_SHAPE_256_BY_16:
      begin
        loc.word = a[7:0];
        loc.lane = `DRB_LANE_16;
        loc.off = 4'h0;
      end
      DRB_RAM_SHAPE_512_BY_8:
      begin
        loc.word = a[8:1];
        loc.lane = `DRB_LANE_8;
        loc.off = {a[0], 3'h0};
      end
      DRB_RAM_SHAPE_1024_BY_4:
      begin
        loc.word = a[9:2];
        loc.lane = `DRB_LANE_4;
        loc.off = {a[1:0], 2'h0};
      end
      default:
      begin
        loc.word = a[10:3];
        loc.lane = `DRB_LANE_2;
        loc.off = {a[2:0], 1'h0};
      end
    endcase
    return loc;
  endfunction

endpackage

/* File: verilog/drb_edge_det.sv */
// selectable-polarity edge detector for a port clock sampled on i_clk
// assumes the sampled line is synchronous to i_clk
module drb_edge_det
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_line,
  input wire logic i_fall,
  output logic o_pulse
);
  logic prev;

  // previous sample of the port clock
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      prev <= 1'b0;
    else
      prev <= i_line;
  end

  // rising edge by default, falling edge when selected
  assign o_pulse = i_fall ? (prev & ~i_line) : (~prev & i_line);
endmodule // drb_edge_det

/* File: verif/drb_fabric_model.sv */
// fabric model: drives the user write and read ports, one pulse per call
// assumes the bench calls wr, rd and park from a single process
module drb_fabric_model
(
  input wire logic i_clk,
  input wire logic i_wr_fall,
  input wire logic i_rd_fall,
  output drb_pkg::drb_wr_port_s o_wr,
  output drb_pkg::drb_rd_port_s o_rd
);
  timeunit 1ns;
  timeprecision 1ns;
  import drb_pkg::*;

  // port clocks start low with every control inactive
  initial
  begin
    o_wr = '0;
    o_rd = '0;
  end

  // active level for one cycle, then idle; released address, data and mask are inverted
  // so that a late sample never passes for the real value
  task automatic wr(input logic en, input logic gate, input logic [10:0] a,
                    input logic [15:0] d, input logic [15:0] m);
    @(posedge i_clk);
    o_wr <= '{~i_wr_fall, en, gate, a, d, m};
    @(posedge i_clk);
    o_wr <= '{i_wr_fall, 1'b0, 1'b0, ~a, ~d, ~m};
  endtask

  // read pulse, same shape as a write
  task automatic rd(input logic en, input logic gate, input logic [10:0] a);
    @(posedge i_clk);
    o_rd <= '{~i_rd_fall, en, gate, a};
    @(posedge i_clk);
    o_rd <= '{i_rd_fall, 1'b0, 1'b0, ~a};
  endtask

  // park both port clocks at the idle level after a polarity change
  task automatic park;
    @(posedge i_clk);
    o_wr.wr_clk <= i_wr_fall;
    o_rd.rd_clk <= i_rd_fall;
  endtask
endmodule // drb_fabric_model

/* File: verif/tb.sv */
// self-checking bench: block ram against a word-array model
// assumes the fabric model drives the user ports, the bench the rest
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import drb_pkg::*;

  logic i_clk, i_rst, i_wr_clk_fall, i_rd_clk_fall;
  logic i_cfg_active, i_cfg_load;
  drb_shape_e i_shape;
  logic [7:0] i_cfg_addr;
  logic [15:0] i_cfg_data, o_rd_data, exp_rd, d;
  logic [10:0] a;
  drb_wr_port_s wr;
  drb_rd_port_s rd;
  logic [15:0] mem [256];
  int err_count = 0;
  int check_count = 0;

  drb_fabric_model drb_fabric_model_inst (.i_clk, .i_wr_fall(i_wr_clk_fall),
    .i_rd_fall(i_rd_clk_fall), .o_wr(wr), .o_rd(rd));
  drb_block_ram drb_block_ram_inst (.i_clk, .i_rst, .i_shape, .i_wr_clk_fall,
    .i_rd_clk_fall, .i_wr(wr), .i_rd(rd), .i_cfg_active, .i_cfg_load,
    .i_cfg_addr, .i_cfg_data, .o_rd_data);

  // 125 MHz system clock
  initial
  begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  ////////////////////////////////////////
  task automatic close_out;
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t read %h expected %h", $time, got, exp);
    end
  endtask

  // model write: narrow shapes replace only their lane, mask is ignored
  task automatic do_wr(input logic en, input logic gate, input logic [15:0] m);
    int s, w, off, wi;
    logic [15:0] keep;
    s = i_shape;
    w = 16 >> s;
    off = (a % (1 << s)) * w;
    // address bits above the shape are left to the fabric to decode
    wi = (a >> s) & 255;
    keep = (s == 0) ? m : ~(((1 << w) - 1) << off);
    drb_fabric_model_inst.wr(en, gate, a, d, m);
    if (en && gate)
      mem[wi] = (mem[wi] & keep) | ((d << off) & ~keep);
  endtask

  // model read: disabled reads hold the last value
  task automatic do_rd(input logic en, input logic gate);
    int s, w;
    s = i_shape;
    w = 16 >> s;
    drb_fabric_model_inst.rd(en, gate, a);
    if (en && gate)
      exp_rd = (mem[(a >> s) & 255] >> ((a % (1 << s)) * w)) & ((1 << w) - 1);
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    cmp(o_rd_data, exp_rd);
  endtask

  initial
  begin
    void'($urandom(9));
    i_rst = 1'b1;
    i_shape = DRB_RAM_SHAPE_256_BY_16;
    {i_wr_clk_fall, i_rd_clk_fall, i_cfg_load} = '0;
    i_cfg_active = 1'b0;
    i_cfg_addr = '0;
    i_cfg_data = '0;
    exp_rd = '0;
    repeat (4) @(posedge i_clk);
    i_rst <= 1'b0;
    @(negedge i_clk);
    cmp(o_rd_data, 16'h0000);
    // word zero gets a known value first, so the preload can be seen to
    // leave it alone
    a = 11'h000;
    d = 16'($urandom);
    do_wr(1'b1, 1'b1, 16'h0000);
    @(posedge i_clk);
    i_cfg_active <= 1'b1;
    // preload every word; word zero is refused
    for (int i = 0; i < 256; i++)
    begin
      d = 16'($urandom);
      @(posedge i_clk);
      i_cfg_load <= 1'b1;
      i_cfg_addr <= 8'(i);
      i_cfg_data <= d;
      if (i != 0)
        mem[i] = d;
    end
    @(posedge i_clk);
    i_cfg_load <= 1'b0;
    i_cfg_active <= 1'b0;
    a = 11'h000;
    do_rd(1'b1, 1'b1);
    repeat (8)
    begin
      a = 11'($urandom);
      do_rd(1'b1, 1'b1);
    end
    // every shape, each with its own pairing of port clock polarities
    for (int s = 0; s < 4; s++)
    begin
      @(posedge i_clk);
      i_shape <= drb_shape_e'(s);
      i_wr_clk_fall <= s[0];
      i_rd_clk_fall <= s[1];
      drb_fabric_model_inst.park();
      repeat (40)
      begin
        a = 11'($urandom);
        d = 16'($urandom);
        do_wr($urandom % 4 != 0, $urandom % 4 != 0, 16'($urandom));
        a = a ^ 11'h001;
        d = 16'($urandom);
        do_wr(1'b1, 1'b1, 16'($urandom));
        a = a ^ 11'h001;
        do_rd($urandom % 4 != 0, $urandom % 4 != 0);
      end
    end
    close_out;
  end

  // watchdog at several times the expected run of about 1600 cycles
  initial
  begin
    #(8 * 10000);
    err_count++;
    close_out;
  end
endmodule // tb
